// ==== hw/epp_ctl.v ====
// Purpose: Programmer that drives the memory programming strobes
// Assumes: APB slave, pclk 100 MHz, pins are asynchronous
// Notes:   One command at a time; commands sent while busy are dropped
// Notes on behaviour
// - Codes 0 idle,1 read,2 unlock,3 write,4 lock,5 id write,9,10 reads.
// - Validate and address reset are active low; code reset active high.
// - Select: resets high, clear code, one increment per unit, validate.
// - Validate low at least 10 us for write, 100 ns otherwise; here every nonzero code gets 10 us, only code 0 gets 100 ns.
// - Lock flag starts at 0; unlock (code 2) is needed first.
// - Write: resets up, unlock, code reset low, 3 pulses, step, 10 us.
//
// Design decisions made here: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "epp_consts.vh"
module epp_ctl #(
  parameter AW = 13,
  parameter TW = 12
) (
  // Clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output reg         pslverr,
  // Programming strobes
  output reg         addr_reset_n,
  output reg         addr_inc,
  output reg         code_reset,
  output reg         code_inc,
  output reg         validate_n,
  // Data port
  input  wire [7:0]  program_data_port_i,
  output reg  [7:0]  program_data_port_o,
  output reg         program_data_port_oe
);
  // Cycle counts, rounded up
  localparam integer VAL_WR_N =
    (`EPP_VAL_WR_NS + `EPP_CLK_NS - 1) / `EPP_CLK_NS;
  localparam integer VAL_N =
    (`EPP_VAL_NS + `EPP_CLK_NS - 1) / `EPP_CLK_NS;
  localparam integer STB_N =
    (`EPP_STB_NS + `EPP_CLK_NS - 1) / `EPP_CLK_NS;
  localparam integer SET_N =
    (`EPP_SETTLE_NS + `EPP_CLK_NS - 1) / `EPP_CLK_NS;
  // Cut to timer width on purpose; longest count must fit TW bits
  localparam [TW-1:0] VAL_WR_CYC = VAL_WR_N[TW-1:0];
  localparam [TW-1:0] VAL_CYC    = VAL_N[TW-1:0];
  localparam [TW-1:0] STB_CYC    = STB_N[TW-1:0];
  localparam [TW-1:0] SET_CYC    = SET_N[TW-1:0];

  // States
  localparam [3:0] S_IDLE  = 4'h0;
  localparam [3:0] S_ARST  = 4'h1;
  localparam [3:0] S_CLR   = 4'h2;
  localparam [3:0] S_CLRLO = 4'h3;
  localparam [3:0] S_CINCH = 4'h4;
  localparam [3:0] S_CINCL = 4'h5;
  localparam [3:0] S_VAL   = 4'h6;
  localparam [3:0] S_VREC  = 4'h7;
  localparam [3:0] S_RES   = 4'h8;
  localparam [3:0] S_AINCH = 4'h9;
  localparam [3:0] S_AINCL = 4'ha;
  localparam [3:0] S_PARK  = 4'hb;

  reg  [3:0]    state_r;
  reg  [3:0]    code_r;
  reg  [13:0]   cnt_r;
  reg  [7:0]    wdata_r;
  reg  [7:0]    rdata_r;
  reg  [AW-1:0] addr_r;
  reg           drop_r;
  reg           tld_r;
  reg  [TW-1:0] tval_r;
  wire          tdone;
  wire [7:0]    din_s;
  wire          busy;
  wire          setup;
  wire          wr_acc;
  wire          mapped;
  wire          cmd_wr;
  wire [1:0]    act;

  // Pin data crosses into pclk before use
  epp_sync #(.W(8)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (program_data_port_i),
    .dout    (din_s)
  );

  epp_timer #(.W(TW)) u_tmr (
    .pclk    (pclk),
    .presetn (presetn),
    .load    (tld_r),
    .val     (tval_r),
    .done    (tdone)
  );

  assign busy   = (state_r != S_IDLE);
  assign pready = 1'b1;
  assign setup  = psel && !penable;
  assign wr_acc = psel && penable && pwrite;
  assign mapped = (paddr == `EPP_REG_CMD) || (paddr == `EPP_REG_WDATA) ||
                  (paddr == `EPP_REG_STATUS) || (paddr == `EPP_REG_ADDR);
  assign cmd_wr = wr_acc && (paddr == `EPP_REG_CMD);
  assign act    = pwdata[`EPP_CMD_ACT_MSB:`EPP_CMD_ACT_LSB];

  // Read data is latched in the setup cycle so it leaves a flop
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (setup) begin
      pslverr <= !mapped;
      case (paddr)
        `EPP_REG_WDATA:  prdata <= {24'h000000, wdata_r};
        `EPP_REG_STATUS: prdata <= {16'h0000, rdata_r, 6'h00, drop_r, busy};
        `EPP_REG_ADDR:   prdata <= {{(32-AW){1'b0}}, addr_r};
        default:         prdata <= 32'h00000000;
      endcase
    end
  end

  // Write data register and drop flag; a new drop beats the clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdata_r <= `EPP_WDATA_RST;
      drop_r  <= 1'b0;
    end else begin
      if (wr_acc && (paddr == `EPP_REG_WDATA))
        wdata_r <= pwdata[7:0];
      if (cmd_wr && busy)
        drop_r <= 1'b1;
      else if (wr_acc && (paddr == `EPP_REG_STATUS) &&
               pwdata[`EPP_ST_DROP])
        drop_r <= 1'b0;
    end
  end

  // Strobe sequencer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r              <= S_IDLE;
      code_r               <= 4'h0;
      cnt_r                <= 14'h0000;
      rdata_r              <= 8'h00;
      addr_r               <= `EPP_ADDR_RST;
      tld_r                <= 1'b0;
      tval_r               <= {TW{1'b0}};
      addr_reset_n         <= 1'b0;
      addr_inc             <= 1'b0;
      code_reset           <= 1'b0;
      code_inc             <= 1'b0;
      validate_n           <= 1'b1;
      program_data_port_o  <= 8'h00;
      program_data_port_oe <= 1'b0;
    end else begin
      tld_r <= 1'b0;
      case (state_r)
        S_IDLE: begin
          if (cmd_wr) begin
            code_r <= pwdata[`EPP_CMD_CODE_MSB:`EPP_CMD_CODE_LSB];
            cnt_r  <= pwdata[`EPP_CMD_CNT_MSB:`EPP_CMD_CNT_LSB];
            tld_r  <= 1'b1;
            tval_r <= STB_CYC;
            case (act)
              `EPP_ACT_SESSION: begin
                // Fresh session: address and lock flag cleared
                addr_reset_n <= 1'b0;
                code_reset   <= 1'b1;
                addr_r       <= `EPP_ADDR_RST;
                state_r      <= S_ARST;
              end
              `EPP_ACT_STEP: begin
                state_r <= S_AINCL;
              end
              `EPP_ACT_OP: begin
                // Code cleared by a high level on code reset
                code_reset <= 1'b1;
                state_r    <= S_CLR;
              end
              default: begin
                // Device address clears too, so the shadow follows
                addr_reset_n <= 1'b0;
                code_reset   <= 1'b0;
                addr_r       <= `EPP_ADDR_RST;
                state_r      <= S_PARK;
              end
            endcase
          end
        end
        S_PARK: begin
          if (tdone)
            state_r <= S_IDLE;
        end
        S_ARST: begin
          if (tdone) begin
            addr_reset_n <= 1'b1;
            tld_r        <= 1'b1;
            state_r      <= S_PARK;
          end
        end
        S_CLR: begin
          if (tdone) begin
            // Low code reset lets the host drive the port later
            code_reset <= 1'b0;
            tld_r      <= 1'b1;
            state_r    <= (code_r == 4'h0) ? S_VAL : S_CINCL;
            tval_r     <= (code_r == 4'h0) ? VAL_CYC : STB_CYC;
            if (code_r == 4'h0)
              validate_n <= 1'b0;
          end
        end
        S_CINCL: begin
          if (tdone) begin
            code_inc <= 1'b1;
            tld_r    <= 1'b1;
            state_r  <= S_CINCH;
          end
        end
        S_CINCH: begin
          if (tdone) begin
            code_inc <= 1'b0;
            code_r   <= code_r - 4'h1;
            tld_r    <= 1'b1;
            if (code_r == 4'h1) begin
              state_r <= S_CLRLO;
            end else begin
              state_r <= S_CINCL;
            end
          end
        end
        S_CLRLO: begin
          // Settle with write data on the port before validating
          program_data_port_o  <= wdata_r;
          // Device listens while code reset is low, for every nonzero code
          program_data_port_oe <= 1'b1;
          if (tdone) begin
            validate_n <= 1'b0;
            tld_r      <= 1'b1;
            // Port enable is already set here, so every nonzero code gets the long pulse
            tval_r     <= program_data_port_oe ? VAL_WR_CYC : VAL_CYC;
            state_r    <= S_VAL;
          end
        end
        S_VAL: begin
          if (tdone) begin
            validate_n <= 1'b1;
            tld_r      <= 1'b1;
            tval_r     <= STB_CYC;
            state_r    <= S_VREC;
          end
        end
        S_VREC: begin
          if (tdone) begin
            program_data_port_oe <= 1'b0;
            // Device takes the port while code reset is high
            code_reset <= 1'b1;
            tld_r      <= 1'b1;
            tval_r     <= SET_CYC;
            state_r    <= S_RES;
          end
        end
        S_RES: begin
          if (tdone) begin
            // Port value after a write is meaningless, kept anyway
            rdata_r <= din_s;
            state_r <= S_IDLE;
          end
        end
        S_AINCL: begin
          if (cnt_r == 14'h0000) begin
            state_r <= S_IDLE;
          end else if (tdone) begin
            addr_inc <= 1'b1;
            tld_r    <= 1'b1;
            state_r  <= S_AINCH;
          end
        end
        S_AINCH: begin
          if (tdone) begin
            addr_inc <= 1'b0;
            addr_r   <= addr_r + {{(AW-1){1'b0}}, 1'b1};
            cnt_r    <= cnt_r - 14'h0001;
            tld_r    <= 1'b1;
            state_r  <= S_AINCL;
          end
        end
        default: begin
          state_r <= S_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== shared/epp_consts.vh ====
// Purpose: Constants of the programming-port controller
// Assumes: 100 MHz pclk, APB word registers
// Notes:   Times are in ns; cycle counts are derived in the code
`ifndef EPP_CONSTS_VH
`define EPP_CONSTS_VH

// Register byte offsets
`define EPP_REG_CMD     12'h000
`define EPP_REG_WDATA   12'h004
`define EPP_REG_STATUS  12'h008
`define EPP_REG_ADDR    12'h00c

// Command fields
`define EPP_CMD_CODE_LSB  0
`define EPP_CMD_CODE_MSB  3
`define EPP_CMD_ACT_LSB   4
`define EPP_CMD_ACT_MSB   5
`define EPP_CMD_CNT_LSB   8
`define EPP_CMD_CNT_MSB   21

// Actions
`define EPP_ACT_PARK    2'h0
`define EPP_ACT_SESSION 2'h1
`define EPP_ACT_STEP    2'h2
`define EPP_ACT_OP      2'h3

// Status bits
`define EPP_ST_BUSY     0
`define EPP_ST_DROP     1
`define EPP_ST_RD_LSB   8
`define EPP_ST_RD_MSB   15

// Operation codes
`define EPP_OP_STANDBY  4'h0
`define EPP_OP_READ     4'h1
`define EPP_OP_UNLOCK   4'h2
`define EPP_OP_WRITE    4'h3
`define EPP_OP_LOCK     4'h4
`define EPP_OP_IDWR     4'h5
`define EPP_OP_LSREAD   4'h9
`define EPP_OP_IDRD     4'ha

// Reset values
`define EPP_WDATA_RST   8'hff
`define EPP_ADDR_RST    13'h0000

// Timing (ns)
`define EPP_CLK_NS      10
`define EPP_VAL_WR_NS   10000
`define EPP_VAL_NS      100
`define EPP_STB_NS      100
`define EPP_SETTLE_NS   200

`endif

// ==== hw/epp_sync.v ====
// Purpose: Two-flop synchroniser for a bus of pin inputs
// Assumes: Bits are sampled independently
// Notes:   First stage is read only by the second
`timescale 1ns/1ps
`default_nettype none
module epp_sync #(
  parameter W = 8
) (
  // Clock and reset
  input  wire         pclk,
  input  wire         presetn,
  // Data
  input  wire [W-1:0] din,
  output wire [W-1:0] dout
);
  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= {W{1'b0}};
      s2_r <= {W{1'b0}};
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
    end
  end

  assign dout = s2_r;
endmodule
`default_nettype wire

// ==== hw/epp_timer.v ====
// Purpose: Down-counter timing strobe phases
// Assumes: load has priority over counting
// Notes:   done is low in the load cycle
`timescale 1ns/1ps
`default_nettype none
module epp_timer #(
  parameter W = 12
) (
  // Clock and reset
  input  wire         pclk,
  input  wire         presetn,
  // Control
  input  wire         load,
  input  wire [W-1:0] val,
  output wire         done
);
  reg [W-1:0] cnt_r;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= {W{1'b0}};
    end else if (load) begin
      cnt_r <= val;
    end else if (cnt_r != {W{1'b0}}) begin
      cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
    end
  end

  assign done = !load && (cnt_r == {W{1'b0}});
endmodule
`default_nettype wire

// ==== verif/epp_ctl_checker.sv ====
// Purpose: Pin checks for epp_ctl
// Assumes: One clock domain
// Notes:   Validate width counted in helper logic; increment pulses by repetition
`timescale 1ns/1ps
`default_nettype none
module epp_ctl_checker (
  // Clock and reset
  input wire logic       pclk,
  input wire logic       presetn,
  // Strobes
  input wire logic       addr_reset_n,
  input wire logic       addr_inc,
  input wire logic       code_reset,
  input wire logic       code_inc,
  input wire logic       validate_n,
  // Data port
  input wire logic [7:0] program_data_port_o,
  input wire logic       program_data_port_oe
);
  logic [10:0] lo_r;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Saturates so a stuck strobe cannot wrap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) lo_r <= 11'h000;
    else if (validate_n) lo_r <= 11'h000;
    else if (lo_r != 11'h7ff) lo_r <= lo_r + 11'h001;
  end
  sequence s_cinc_hold;
    code_inc [*8];
  endsequence
  sequence s_ainc_hold;
    addr_inc [*8];
  endsequence
  a_val_width: assert property ($rose(validate_n) |-> lo_r >= 11'd10)
    else $error("validate pulse too short");
  a_write_width: assert property (
    $rose(validate_n) && program_data_port_oe |-> lo_r >= 11'd1000)
    else $error("write pulse too short");
  a_val_resets: assert property (
    !validate_n |-> addr_reset_n && !code_reset)
    else $error("validate with a reset asserted");
  a_inc_clear: assert property (
    $rose(code_inc) |-> !code_reset && validate_n)
    else $error("code pulse during reset or validate");
  a_no_clash: assert property (code_reset |-> !program_data_port_oe)
    else $error("host drives port while device drives");
  a_data_hold: assert property (
    !validate_n && !$fell(validate_n) |-> $stable(program_data_port_o))
    else $error("data moved during validate");
  a_cinc_pulse: assert property ($rose(code_inc) |-> s_cinc_hold)
    else $error("code pulse too short");
  a_ainc_pulse: assert property (
    $rose(addr_inc) |-> addr_reset_n ##0 s_ainc_hold)
    else $error("address pulse bad");
endmodule
bind epp_ctl epp_ctl_checker u_chk (.pclk, .presetn, .addr_reset_n,
  .addr_inc, .code_reset, .code_inc, .validate_n, .program_data_port_o,
  .program_data_port_oe);
`default_nettype wire

// ==== verif/epp_dev_model.sv ====
// Purpose: Behavioural programming port of the memory device
// Assumes: Strobes come from the controller pins
// Notes:   A released port shows inverted data, not stale data
`timescale 1ns/1ps
`default_nettype none
`include "epp_consts.vh"
module epp_dev_model (
  // Strobes
  input  wire logic       addr_reset_n,
  input  wire logic       addr_inc,
  input  wire logic       code_reset,
  input  wire logic       code_inc,
  input  wire logic       validate_n,
  // Data port
  input  wire logic [7:0] host_o,
  input  wire logic       host_oe,
  output wire logic [7:0] pin_q
);
  logic [7:0]  mem [0:8191];
  logic [7:0]  id [0:63];
  logic [12:0] addr_r = 13'h0000;
  logic [3:0]  code_r = 4'h0;
  logic [7:0]  q_r = 8'h00;
  logic        flag_r = 1'b0;
  logic        cell_r = 1'b1;
  logic [7:0]  din;
  realtime     t_fall = 0.0;
  initial begin
    foreach (mem[i]) mem[i] = 8'hff;
    foreach (id[i]) id[i] = 8'hff;
  end
  assign din = host_oe ? host_o : ~q_r;
  assign pin_q = code_reset ? q_r : din;
  always @(posedge addr_inc or negedge addr_reset_n) begin
    if (!addr_reset_n) addr_r <= 13'h0000;
    else addr_r <= addr_r + 13'h0001;
  end
  always @(posedge code_inc or posedge code_reset) begin
    if (code_reset) code_r <= 4'h0;
    else code_r <= code_r + 4'h1;
  end
  always @(negedge validate_n) t_fall = $realtime;
  always @(posedge validate_n or negedge addr_reset_n) begin
    if (!addr_reset_n) flag_r <= 1'b0;
    else case (code_r)
      `EPP_OP_READ: q_r <= mem[addr_r];
      `EPP_OP_UNLOCK: begin
        if (cell_r) flag_r <= 1'b1;
        q_r <= {7'h00, flag_r | cell_r};
      end
      `EPP_OP_WRITE: begin
        if (flag_r && $realtime - t_fall >= 10000.0)
          mem[addr_r] <= mem[addr_r] & din;
        q_r <= ~q_r;
      end
      `EPP_OP_LOCK: if (flag_r) cell_r <= 1'b0;
      `EPP_OP_IDWR:
        if (flag_r && addr_r < 13'd64)
          id[addr_r[5:0]] <= id[addr_r[5:0]] & din;
      `EPP_OP_LSREAD: q_r <= {7'h00, flag_r};
      `EPP_OP_IDRD: q_r <= id[addr_r[5:0]];
      default: ;
    endcase
  end
endmodule
`default_nettype wire

// ==== verif/epp_ctl_tb_top.sv ====
// Purpose: Self-checking bench for epp_ctl with device model
// Assumes: Zero wait APB, 100 MHz pclk
// Notes:   Expected bytes follow the device rules
`timescale 1ns/1ps
`default_nettype none
`include "epp_consts.vh"
module epp_ctl_tb_top;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic        pready, pslverr, addr_reset_n, addr_inc, code_reset;
  logic        code_inc, validate_n, program_data_port_oe;
  logic [31:0] prdata, rdat;
  logic [7:0]  program_data_port_i, program_data_port_o;
  logic        rerr;
  int          fails = 0;
  int          tests_run = 0;
  always #5 pclk = ~pclk;
  epp_ctl u_epp_ctl (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .prdata, .pslverr, .addr_reset_n, .addr_inc,
    .code_reset, .code_inc, .validate_n, .program_data_port_i,
    .program_data_port_o, .program_data_port_oe);
  epp_dev_model u_epp_dev_model (.addr_reset_n, .addr_inc, .code_reset,
    .code_inc, .validate_n, .host_o(program_data_port_o),
    .host_oe(program_data_port_oe), .pin_q(program_data_port_i));
  task automatic chk(input string nm, input logic [31:0] s,
                     input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Polls busy; the watchdog ends a hang
  task automatic cmd(input logic [31:0] c);
    apb(1'b1, `EPP_REG_CMD, c);
    do apb(1'b0, `EPP_REG_STATUS, 32'h0); while (rdat[`EPP_ST_BUSY] !== 1'b0);
  endtask
  task automatic opchk(input string nm, input logic [3:0] c,
                       input logic [7:0] e);
    cmd(32'h30 | c);
    chk(nm, rdat[15:8], e);
  endtask
  task automatic t_regs;
    apb(1'b0, `EPP_REG_WDATA, 32'h0);
    chk("wdata", rdat, 32'h0000_00ff);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped", {rdat[30:0], rerr}, 32'h1);
  endtask
  task automatic t_unlock;
    cmd(32'h10);
    opchk("locked", 4'h9, 8'h00);
    opchk("unlock", 4'h2, 8'h01);
  endtask
  task automatic t_write;
    cmd(32'h520);
    apb(1'b0, `EPP_REG_ADDR, 32'h0);
    chk("addr", rdat, 32'h5);
    apb(1'b1, `EPP_REG_WDATA, 32'h3c);
    cmd(32'h33);
    opchk("rd1", 4'h1, 8'h3c);
    apb(1'b1, `EPP_REG_WDATA, 32'hf0);
    cmd(32'h33);
    opchk("rd2", 4'h1, 8'h30);
  endtask
  task automatic t_id_undef;
    cmd(32'h120);
    opchk("blank", 4'h1, 8'hff);
    apb(1'b1, `EPP_REG_WDATA, 32'h81);
    cmd(32'h35);
    opchk("id", 4'ha, 8'h81);
    apb(1'b1, `EPP_REG_WDATA, 32'h00);
    cmd(32'h37);
    cmd(32'h30);
    opchk("undef", 4'h1, 8'hff);
    opchk("flag", 4'h9, 8'h01);
  endtask
  task automatic t_lock;
    cmd(32'h34);
    cmd(32'h10);
    opchk("relock", 4'h2, 8'h00);
    cmd(32'h33);
    opchk("nowrite", 4'h1, 8'hff);
    cmd(32'h620);
    opchk("idlocked", 4'ha, 8'h81);
  endtask
  task automatic t_drop;
    apb(1'b1, `EPP_REG_CMD, 32'h30);
    cmd(32'h39);
    chk("drop", rdat[`EPP_ST_DROP], 32'h1);
    apb(1'b1, `EPP_REG_STATUS, 32'h2);
    apb(1'b0, `EPP_REG_STATUS, 32'h0);
    chk("dropclr", rdat[`EPP_ST_DROP], 32'h0);
    cmd(32'h00);
    apb(1'b0, `EPP_REG_ADDR, 32'h0);
    chk("parkaddr", rdat, 32'h0);
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    #600000;
    fails++;
    give_verdict;
  end
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_unlock;
    t_write;
    t_id_undef;
    t_lock;
    t_drop;
    give_verdict;
  end
endmodule
`default_nettype wire
